// *** src/vssf_pkg.sv ***
// Package of constants and types for the output setpoint, slew, scale and frequency registers
package vssf_pkg;

    // Command codes
    localparam logic [7:0]  CODE_MARGIN_LOW = 8'h26;
    localparam logic [7:0]  CODE_SLEW       = 8'h27;
    localparam logic [7:0]  CODE_SCALE      = 8'h29;
    localparam logic [7:0]  CODE_FREQ       = 8'h33;
    localparam logic [7:0]  CODE_STATUS     = 8'h7E;

    // Stored defaults
    localparam logic [15:0] RST_MARGIN_LOW  = 16'h0123;
    localparam logic [15:0] RST_SLEW        = 16'hE002;
    localparam logic [15:0] RST_SCALE       = 16'hE808;
    localparam logic [15:0] RST_FREQ        = 16'h0258;

    // LINEAR11 field layout
    localparam int          POW_MSB         = 15;
    localparam int          POW_LSB         = 11;
    localparam int          FRAC_SIGN_BIT   = 10;
    localparam int          FRAC_MSB        = 9;
    localparam logic [4:0]  SLEW_POWER      = 5'h1C;
    localparam logic [4:0]  SCALE_POWER     = 5'h1D;
    localparam logic [4:0]  FREQ_POWER      = 5'h00;

    // Acceptance limits
    localparam logic [15:0] VOUT_MIN_CODE   = 16'h009A;
    localparam logic [15:0] VOUT_MAX_CODE   = 16'h1C00;
    localparam logic [10:0] SLEW_MIN_FRAC   = 11'h001;
    localparam logic [10:0] SLEW_MAX_FRAC   = 11'h020;
    localparam logic [10:0] FREQ_MIN_KHZ    = 11'h12C;
    localparam logic [10:0] FREQ_MAX_KHZ    = 11'h5DC;
    localparam logic [10:0] FREQ_STEP_KHZ   = 11'h032;

    // Accepted scale codes
    localparam logic [15:0] SCALE_1_0       = 16'hE808;
    localparam logic [15:0] SCALE_0_5       = 16'hE804;
    localparam logic [15:0] SCALE_0_25      = 16'hE802;
    localparam logic [15:0] SCALE_0_125     = 16'hE801;

    // Band limits for pin-set scale, in 2^-9 V codes
    localparam logic [15:0] BAND_1V8_CODE   = 16'h039A;
    localparam logic [15:0] BAND_3V3_CODE   = 16'h069A;
    localparam logic [15:0] BAND_5V0_CODE   = 16'h0A00;

    // Status byte layout
    localparam int          STAT_BAD_CMD    = 7;
    localparam int          STAT_BAD_DATA   = 6;

    // Ramp timing: LSB sizes and clock rate
    localparam int          CLK_MHZ         = 125;
    localparam int          VOUT_LSB_NV     = 1953125;
    localparam int          SLEW_LSB_UV_US  = 62500;
    localparam int          RAMP_THRESH     = (VOUT_LSB_NV / 1000 * CLK_MHZ * 1000
                                               + 0) / SLEW_LSB_UV_US;

    typedef enum logic [1:0] {
        OP_NOMINAL     = 2'b00,
        OP_MARGIN_LOW  = 2'b01,
        OP_MARGIN_HIGH = 2'b10
    } vssf_op_e;

    typedef struct packed {
        logic        wr;
        logic [7:0]  code;
        logic [15:0] data;
    } vssf_req_s;

    typedef struct packed {
        logic        err;
        logic [15:0] data;
    } vssf_rsp_s;

endpackage

// *** src/vssf_regs.sv ***
// Setpoint, slew, scale and frequency register bank with link crossing and output ramp
`timescale 1ns/1ps
module vssf_regs
    import vssf_pkg::*;
#(
    parameter logic [15:0] NVM_MARGIN_LOW = RST_MARGIN_LOW,
    parameter logic [15:0] NVM_SLEW       = RST_SLEW,
    parameter logic [15:0] NVM_SCALE      = RST_SCALE,
    parameter logic [15:0] NVM_FREQ       = RST_FREQ
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        link_clk_i,
    input  wire logic        link_req_valid_i,
    input  wire vssf_req_s   link_req_i,
    output logic             link_ready_o,
    output logic             link_rsp_valid_o,
    output vssf_rsp_s        link_rsp_o,
    input  wire vssf_op_e    op_mode_i,
    input  wire logic        output_on_i,
    input  wire logic [15:0] vout_cmd_i,
    input  wire logic [15:0] margin_high_i,
    input  wire logic        pin_set_i,
    input  wire logic [15:0] pin_vout_i,
    input  wire logic [15:0] sense_vout_i,
    output logic [15:0]      setpoint_o,
    output logic [15:0]      scaled_setpoint_o,
    output logic [15:0]      scaled_sense_o,
    output logic [15:0]      scale_code_o,
    output logic [10:0]      freq_khz_o,
    output logic [10:0]      slew_frac_o,
    output logic             alert_o
);

    // Link domain
    vssf_req_s   req_hold;
    logic        req_tog;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_s3;
    // Core domain
    logic        req_s1;
    logic        req_s2;
    logic        req_s3;
    logic        req_seen;
    vssf_rsp_s   rsp_hold;
    logic        ack_tog;
    logic [15:0] margin_low;
    logic [15:0] slew;
    logic [15:0] scale;
    logic [15:0] freq;
    logic [7:0]  status;
    logic [15:0] target;
    logic [11:0] ramp_acc;
    logic [15:0] eff_scale;
    logic        dec_hit;
    logic        dec_ok;
    logic [15:0] dec_rdata;
    logic        wr_ok;
    logic        wr_bad;

    // Request capture; hold stays stable until the answer comes back across
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_hold     <= '0;
            req_tog      <= 1'b0;
            link_ready_o <= 1'b1;
        end else if (link_ready_o && link_req_valid_i) begin
            req_hold     <= link_req_i;
            req_tog      <= ~req_tog;
            link_ready_o <= 1'b0;
        end else if (ack_s2 ^ ack_s3) begin
            link_ready_o <= 1'b1;
        end
    end

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_s3 <= 1'b0;
        end else begin
            ack_s1 <= ack_tog;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
        end
    end

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            link_rsp_valid_o <= 1'b0;
            link_rsp_o       <= '0;
        end else begin
            link_rsp_valid_o <= ack_s2 ^ ack_s3;
            if (ack_s2 ^ ack_s3) begin
                link_rsp_o <= rsp_hold;
            end
        end
    end

    // Toggle handshake into the core clock
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end else begin
            req_s1 <= req_tog;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end

    assign req_seen = req_s2 ^ req_s3;

    // Decode and range checks on the held request
    always_comb begin
        dec_hit   = 1'b1;
        dec_ok    = 1'b1;
        dec_rdata = '0;
        case (req_hold.code)
            CODE_MARGIN_LOW: begin
                dec_rdata = margin_low;
                dec_ok    = (req_hold.data >= VOUT_MIN_CODE)
                            && (req_hold.data <= VOUT_MAX_CODE);
            end
            CODE_SLEW: begin
                dec_rdata = slew;
                dec_ok    = (req_hold.data[POW_MSB:POW_LSB] == SLEW_POWER)
                            && (req_hold.data[FRAC_SIGN_BIT:0] >= SLEW_MIN_FRAC)
                            && (req_hold.data[FRAC_SIGN_BIT:0] <= SLEW_MAX_FRAC);
            end
            CODE_SCALE: begin
                dec_rdata = scale;
                dec_ok    = (req_hold.data == SCALE_1_0) || (req_hold.data == SCALE_0_5)
                            || (req_hold.data == SCALE_0_25)
                            || (req_hold.data == SCALE_0_125);
            end
            CODE_FREQ: begin
                dec_rdata = freq;
                dec_ok    = (req_hold.data[POW_MSB:POW_LSB] == FREQ_POWER)
                            && (req_hold.data[FRAC_SIGN_BIT:0] >= FREQ_MIN_KHZ)
                            && (req_hold.data[FRAC_SIGN_BIT:0] <= FREQ_MAX_KHZ)
                            && ((req_hold.data[FRAC_SIGN_BIT:0] % FREQ_STEP_KHZ)
                                == 11'h000);
            end
            CODE_STATUS: begin
                dec_rdata = {8'h00, status};
            end
            default: begin
                dec_hit = 1'b0;
                dec_ok  = 1'b0;
            end
        endcase
    end

    assign wr_ok  = req_seen && req_hold.wr && dec_ok;
    assign wr_bad = req_seen && !dec_ok && (req_hold.wr || !dec_hit);

    // Register storage; rejected writes never reach these
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            margin_low <= NVM_MARGIN_LOW;
            slew       <= NVM_SLEW;
            scale      <= NVM_SCALE;
            freq       <= NVM_FREQ;
        end else if (wr_ok) begin
            unique case (req_hold.code)
                CODE_MARGIN_LOW: margin_low <= req_hold.data;
                CODE_SLEW:       slew       <= req_hold.data;
                CODE_SCALE:      scale      <= req_hold.data;
                CODE_FREQ:       freq       <= req_hold.data;
                default:         margin_low <= margin_low;
            endcase
        end
    end

    // Sticky error flags; a new error beats a clear in the same cycle
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            status <= '0;
        end else begin
            if (wr_ok && req_hold.code == CODE_STATUS) begin
                status <= status & ~req_hold.data[7:0];
            end
            if (wr_bad) begin
                status[STAT_BAD_DATA] <= dec_hit;
                status[STAT_BAD_CMD]  <= !dec_hit;
            end
            if (wr_bad && dec_hit) begin
                status[STAT_BAD_CMD] <= status[STAT_BAD_CMD]
                    && !(wr_ok && req_hold.code == CODE_STATUS && req_hold.data[STAT_BAD_CMD]);
            end else if (wr_bad) begin
                status[STAT_BAD_DATA] <= status[STAT_BAD_DATA]
                    && !(wr_ok && req_hold.code == CODE_STATUS && req_hold.data[STAT_BAD_DATA]);
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            alert_o <= 1'b0;
        end else begin
            alert_o <= (status != 8'h00);
        end
    end

    // Answer; written on the same edge as the toggle and read only after the toggle crosses two link flops, so the link never sees a half-written word
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_hold <= '0;
            ack_tog  <= 1'b0;
        end else if (req_seen) begin
            // Range checks judge write data only; a read fails only on an unknown code
            rsp_hold.err  <= req_hold.wr ? !dec_ok : !dec_hit;
            rsp_hold.data <= req_hold.wr ? 16'h0000 : dec_rdata;
            ack_tog       <= ~ack_tog;
        end
    end

    // Target selection by operating mode
    always_comb begin
        unique case (op_mode_i)
            OP_MARGIN_LOW:  target = margin_low;
            OP_MARGIN_HIGH: target = margin_high_i;
            default:        target = vout_cmd_i;
        endcase
    end

    // Ramp: the accumulator adds the slew mantissa each cycle until it reaches RAMP_THRESH, then clears for one 2^-9 V step
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            setpoint_o <= 16'h0000;
            ramp_acc   <= '0;
        end else if (!output_on_i) begin
            setpoint_o <= 16'h0000;
            ramp_acc   <= '0;
        end else if (setpoint_o == 16'h0000) begin
            setpoint_o <= target;
            ramp_acc   <= '0;
        end else if (setpoint_o != target) begin
            if (ramp_acc >= 12'(RAMP_THRESH)) begin
                ramp_acc   <= '0;
                setpoint_o <= (target > setpoint_o) ? setpoint_o + 16'h0001
                                                    : setpoint_o - 16'h0001;
            end else begin
                ramp_acc <= ramp_acc + {1'b0, slew[FRAC_SIGN_BIT:0]};
            end
        end else begin
            ramp_acc <= '0;
        end
    end

    // Pin-set output picks its band; otherwise the host value stands
    always_comb begin
        if (!pin_set_i) begin
            eff_scale = scale;
        end else if (pin_vout_i < BAND_1V8_CODE) begin
            eff_scale = SCALE_1_0;
        end else if (pin_vout_i < BAND_3V3_CODE) begin
            eff_scale = SCALE_0_5;
        end else if (pin_vout_i <= BAND_5V0_CODE) begin
            eff_scale = SCALE_0_25;
        end else begin
            eff_scale = SCALE_0_125;
        end
    end

    // Mantissa over 8 gives the factor; both paths scale the same way
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            scaled_setpoint_o <= '0;
            scaled_sense_o    <= '0;
            scale_code_o      <= RST_SCALE;
            freq_khz_o        <= RST_FREQ[FRAC_SIGN_BIT:0];
            slew_frac_o       <= RST_SLEW[FRAC_SIGN_BIT:0];
        end else begin
            // Product is formed at full width so high codes do not wrap before the shift
            scaled_setpoint_o <= 16'((32'(setpoint_o) * 32'(eff_scale[3:0])) >> 3);
            scaled_sense_o    <= 16'((32'(sense_vout_i) * 32'(eff_scale[3:0])) >> 3);
            scale_code_o      <= eff_scale;
            freq_khz_o        <= freq[FRAC_SIGN_BIT:0];
            slew_frac_o       <= slew[FRAC_SIGN_BIT:0];
        end
    end

endmodule

// *** dv/vssf_regs_monitor.sv ***
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
module vssf_regs_monitor
    import vssf_pkg::*;
(
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        link_clk_i,
    input wire logic        link_req_valid_i,
    input wire logic        link_ready_o,
    input wire logic        link_rsp_valid_o,
    input wire logic        output_on_i,
    input wire logic        pin_set_i,
    input wire logic [15:0] pin_vout_i,
    input wire logic [15:0] sense_vout_i,
    input wire logic [15:0] setpoint_o,
    input wire logic [15:0] scaled_setpoint_o,
    input wire logic [15:0] scaled_sense_o,
    input wire logic [15:0] scale_code_o,
    input wire logic [10:0] freq_khz_o,
    input wire logic [10:0] slew_frac_o
);
    function automatic logic [15:0] band(input logic [15:0] v);
        return v < BAND_1V8_CODE ? SCALE_1_0 : v < BAND_3V3_CODE ? SCALE_0_5 :
               v <= BAND_5V0_CODE ? SCALE_0_25 : SCALE_0_125;
    endfunction

    a_rsp_one_pulse:
        assert property (@(posedge link_clk_i) disable iff (rst_i)
            link_rsp_valid_o |=> !link_rsp_valid_o) else $error("answer held too long");
    a_answer_bound:
        assert property (@(posedge link_clk_i) disable iff (rst_i)
            link_req_valid_i && link_ready_o |=> !link_ready_o [*2] ##[1:10]
            (link_rsp_valid_o && link_ready_o)) else $error("answer late or ready wrong");
    a_slew_legal:
        assert property (@(posedge mclk_i) disable iff (rst_i)
            slew_frac_o inside {[11'h001:11'h020]}) else $error("slew out of range");
    a_freq_legal:
        assert property (@(posedge mclk_i) disable iff (rst_i)
            freq_khz_o inside {[11'h12C:11'h5DC]} && freq_khz_o % 11'h032 == 11'h000)
            else $error("frequency not legal");
    a_scale_legal:
        assert property (@(posedge mclk_i) disable iff (rst_i)
            scale_code_o inside {16'hE808, 16'hE804, 16'hE802, 16'hE801})
            else $error("scale code not legal");
    a_off_zero:
        assert property (@(posedge mclk_i) disable iff (rst_i)
            !output_on_i |=> setpoint_o == 16'h0000) else $error("setpoint not zero when off");
    a_ramp_step:
        assert property (@(posedge mclk_i) disable iff (rst_i)
            output_on_i && $past(output_on_i) && $past(output_on_i, 2) |->
            setpoint_o == $past(setpoint_o) || setpoint_o == $past(setpoint_o) + 16'h0001
            || setpoint_o == $past(setpoint_o) - 16'h0001) else $error("setpoint jumped");
    a_pin_band:
        assert property (@(posedge mclk_i) disable iff (rst_i)
            pin_set_i && $past(pin_set_i) && $stable(pin_vout_i) |=>
            scale_code_o == band($past(pin_vout_i))) else $error("band scale wrong");
    a_scaled_sense:
        assert property (@(posedge mclk_i) disable iff (rst_i)
            $stable(sense_vout_i) && $stable(scale_code_o) |=> !$stable(scale_code_o) ||
            scaled_sense_o == 16'((32'($past(sense_vout_i)) * 32'(scale_code_o[3:0])) >> 3))
            else $error("scaled sense wrong");
    a_scaled_set:
        assert property (@(posedge mclk_i) disable iff (rst_i)
            output_on_i |=> scaled_setpoint_o ==
            16'((32'($past(setpoint_o)) * 32'(scale_code_o[3:0])) >> 3))
            else $error("scaled setpoint wrong");
endmodule

bind vssf_regs vssf_regs_monitor u_mon (.mclk_i(mclk_i), .rst_i(rst_i),
    .link_clk_i(link_clk_i), .link_req_valid_i(link_req_valid_i),
    .link_ready_o(link_ready_o), .link_rsp_valid_o(link_rsp_valid_o),
    .output_on_i(output_on_i), .pin_set_i(pin_set_i), .pin_vout_i(pin_vout_i),
    .sense_vout_i(sense_vout_i), .setpoint_o(setpoint_o), .scaled_sense_o(scaled_sense_o),
    .scaled_setpoint_o(scaled_setpoint_o),
    .scale_code_o(scale_code_o), .freq_khz_o(freq_khz_o), .slew_frac_o(slew_frac_o));

// *** dv/vssf_host_model.sv ***
// Host controller model issuing one command at a time on the link
`timescale 1ns/1ps
module vssf_host_model
    import vssf_pkg::*;
(
    input  wire logic      link_clk_i,
    input  wire logic      link_ready_i,
    input  wire logic      link_rsp_valid_i,
    input  wire vssf_rsp_s link_rsp_i,
    output logic           link_req_valid_o,
    output vssf_req_s      link_req_o
);
    initial begin
        link_req_valid_o = 1'b0;
        link_req_o = '0;
    end

    // One request per call; valid is held until ready, and each wait gives up after 20 link edges
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output vssf_rsp_s r);
        int n;
        @(posedge link_clk_i);
        #1;
        link_req_o = {w, c, d};
        link_req_valid_o = 1'b1;
        n = 0;
        do begin
            @(posedge link_clk_i);
            n++;
        end while (link_ready_i !== 1'b1 && n < 20);
        #1;
        link_req_valid_o = 1'b0;
        // Released lines show junk, not the stale word
        link_req_o = ~link_req_o;
        n = 0;
        do begin
            @(posedge link_clk_i);
            n++;
        end while (link_rsp_valid_i !== 1'b1 && n < 20);
        // A missing answer hands back unknowns so the caller's compare fails
        r = (link_rsp_valid_i === 1'b1) ? link_rsp_i : 'x;
    endtask
endmodule

// *** dv/vssf_regs_tb_top.sv ***
// Testbench for the setpoint, slew, scale and frequency register bank
`timescale 1ns/1ps
module vssf_regs_tb_top
    import vssf_pkg::*;
;
    localparam logic [24:0] ROWS [23] = '{
        {8'h26, 16'h0099, 1'b1}, {8'h26, 16'h1C01, 1'b1}, {8'h26, 16'h009A, 1'b0},
        {8'h26, 16'h1C00, 1'b0}, {8'h26, 16'h0200, 1'b0}, {8'h27, 16'hE000, 1'b1},
        {8'h27, 16'hE021, 1'b1}, {8'h27, 16'hF002, 1'b1}, {8'h27, 16'hE401, 1'b1},
        {8'h27, 16'hE001, 1'b0}, {8'h27, 16'hE020, 1'b0}, {8'h29, 16'hE803, 1'b1},
        {8'h29, 16'hE800, 1'b1}, {8'h29, 16'hE801, 1'b0}, {8'h29, 16'hE802, 1'b0},
        {8'h29, 16'hE804, 1'b0}, {8'h29, 16'hE808, 1'b0}, {8'h33, 16'h0113, 1'b1},
        {8'h33, 16'h05F0, 1'b1}, {8'h33, 16'h0145, 1'b1}, {8'h33, 16'h0A58, 1'b1},
        {8'h33, 16'h05DC, 1'b0}, {8'h33, 16'h0258, 1'b0}};
    localparam logic [31:0] BANDS [6] = '{32'h0399E808, 32'h039AE804, 32'h0699E804,
                                          32'h069AE802, 32'h0A00E802, 32'h0A01E801};
    logic        mclk_i = 1'b0;
    logic        link_clk_i = 1'b0;
    logic        rst_i, link_req_valid_i, link_ready_o, link_rsp_valid_o;
    logic        output_on_i, pin_set_i, alert_o, bad;
    vssf_req_s   link_req_i;
    vssf_rsp_s   link_rsp_o, r;
    vssf_op_e    op_mode_i;
    logic [15:0] vout_cmd_i, margin_high_i, pin_vout_i, sense_vout_i, d;
    logic [15:0] setpoint_o, scaled_setpoint_o, scaled_sense_o, scale_code_o;
    logic [15:0] shadow [256];
    logic [10:0] freq_khz_o, slew_frac_o;
    logic [7:0]  c;
    int          n_mismatch = 0;
    int          tests_run = 0;

    always #4 mclk_i = ~mclk_i;
    initial begin
        // Odd offset keeps the link edges off the core edges
        #3.3;
        forever #32 link_clk_i = ~link_clk_i;
    end

    vssf_regs DUT (.mclk_i(mclk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
        .link_req_valid_i(link_req_valid_i), .link_req_i(link_req_i),
        .link_ready_o(link_ready_o), .link_rsp_valid_o(link_rsp_valid_o),
        .link_rsp_o(link_rsp_o), .op_mode_i(op_mode_i), .output_on_i(output_on_i),
        .vout_cmd_i(vout_cmd_i), .margin_high_i(margin_high_i), .pin_set_i(pin_set_i),
        .pin_vout_i(pin_vout_i), .sense_vout_i(sense_vout_i), .setpoint_o(setpoint_o),
        .scaled_setpoint_o(scaled_setpoint_o), .scaled_sense_o(scaled_sense_o),
        .scale_code_o(scale_code_o), .freq_khz_o(freq_khz_o), .slew_frac_o(slew_frac_o),
        .alert_o(alert_o));
    vssf_host_model u_host (.link_clk_i(link_clk_i), .link_ready_i(link_ready_o),
        .link_rsp_valid_i(link_rsp_valid_o), .link_rsp_i(link_rsp_o),
        .link_req_valid_o(link_req_valid_i), .link_req_o(link_req_i));

    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        u_host.xfer(1'b0, a, 16'h0000, r);
        chk("read word", {1'b0, e}, r);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    task automatic do_reset();
        rst_i = 1'b1;
        cyc(20);
        rst_i = 1'b0;
        rd(8'h26, 16'h0123);
        rd(8'h27, 16'hE002);
        rd(8'h29, 16'hE808);
        rd(8'h33, 16'h0258);
        chk("slew mantissa", 17'h00002, {6'h00, slew_frac_o});
        chk("freq mantissa", 17'h00258, {6'h00, freq_khz_o});
        $display("reset test done");
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_mismatch++;
        $display("watchdog expired");
        end_sim();
    end

    initial begin
        op_mode_i = OP_NOMINAL;
        output_on_i = 1'b0;
        vout_cmd_i = 16'h0202;
        margin_high_i = 16'h0203;
        pin_set_i = 1'b0;
        pin_vout_i = 16'h0100;
        sense_vout_i = 16'h0800;
        shadow = '{default: 16'h0000};
        shadow[CODE_MARGIN_LOW] = RST_MARGIN_LOW;
        shadow[CODE_SLEW] = RST_SLEW;
        shadow[CODE_SCALE] = RST_SCALE;
        shadow[CODE_FREQ] = RST_FREQ;
        do_reset();
        foreach (ROWS[i]) begin
            {c, d, bad} = ROWS[i];
            u_host.xfer(1'b1, c, d, r);
            chk("write status", {bad, 16'h0000}, r);
            if (!bad) shadow[c] = d;
            rd(c, shadow[c]);
        end
        chk("slew out", 17'h00020, {6'h00, slew_frac_o});
        chk("freq out", 17'h00258, {6'h00, freq_khz_o});
        chk("alert", 17'h00001, {16'h0000, alert_o});
        rd(8'h7E, 16'h0040);
        u_host.xfer(1'b1, 8'h30, 16'h1234, r);
        chk("unknown code", 17'h10000, r);
        rd(8'h7E, 16'h00C0);
        u_host.xfer(1'b1, 8'h7E, 16'h00C0, r);
        rd(8'h7E, 16'h0000);
        cyc(10);
        chk("alert clear", 17'h00000, {16'h0000, alert_o});
        $display("register rows test done");
        op_mode_i = OP_MARGIN_LOW;
        output_on_i = 1'b1;
        cyc(3);
        chk("turn on jump", {1'b0, 16'h0200}, {1'b0, setpoint_o});
        op_mode_i = OP_NOMINAL;
        cyc(3);
        chk("no jump", {1'b0, 16'h0200}, {1'b0, setpoint_o});
        cyc(400);
        chk("ramp end", {1'b0, 16'h0202}, {1'b0, setpoint_o});
        chk("scaled set", {1'b0, 16'h0202}, {1'b0, scaled_setpoint_o});
        op_mode_i = OP_MARGIN_HIGH;
        cyc(200);
        chk("margin high", {1'b0, 16'h0203}, {1'b0, setpoint_o});
        output_on_i = 1'b0;
        cyc(3);
        chk("turn off", 17'h00000, {1'b0, setpoint_o});
        pin_set_i = 1'b1;
        foreach (BANDS[i]) begin
            pin_vout_i = BANDS[i][31:16];
            cyc(4);
            chk("band scale", {1'b0, BANDS[i][15:0]}, {1'b0, scale_code_o});
        end
        cyc(3);
        chk("scaled sense", 17'h00100, {1'b0, scaled_sense_o});
        $display("output test done");
        pin_set_i = 1'b0;
        do_reset();
        end_sim();
    end
endmodule
